/* File: rtl/wcc_pkg.sv */
// Purpose: shared constants and types of the wetting current configuration bank
// Assumes: 20 MHz core clock, registers indexed by word, byte address = 4 * index
// Notes: register indices are word numbers on the bus
package wcc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PULSE_UNIT_NS = 64000;
  localparam int unsigned PULSE_UNIT_CYC = PULSE_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned NUM_INPUTS = 24;
  localparam int unsigned NUM_GROUPS = 4;
  localparam int unsigned GROUP_SIZE = 6;
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned ADDR_W = 10;

  localparam logic [7:0] IDX_UPPER_PAIRS = 8'h1e;
  localparam logic [7:0] IDX_TIMING_LEVEL = 8'h1f;
  localparam logic [7:0] IDX_INPUT_ENABLE = 8'h20;

  localparam int unsigned TIME_LSB = 4;
  localparam int unsigned TIME_MSB = 6;
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned LEVEL_MSB = 3;
  localparam int unsigned PAIR_CODE_W = 3;

  localparam logic [11:0] UPPER_PAIRS_RST = 12'h000;
  localparam logic [6:0] TIMING_LEVEL_RST = 7'h00;
  localparam logic [23:0] INPUT_ENABLE_RST = 24'h00_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // analog current selection driven to each continuous pair source
  typedef enum logic [2:0] {
    WCC_CUR_NONE,
    WCC_CUR_1MA,
    WCC_CUR_2MA,
    WCC_CUR_5MA,
    WCC_CUR_10MA,
    WCC_CUR_15MA
  } wcc_cur_t;

  typedef struct packed {
    logic [2:0] act_time;
    logic [3:0] group_15ma;
  } wcc_pulse_cfg_t;

  typedef enum logic {
    WCC_IDLE,
    WCC_ACTIVE
  } wcc_state_t;
endpackage : wcc_pkg

/* File: rtl/wcc_level_dec.sv */
// Purpose: decode the four pair wetting current codes
// Assumes: codes come straight from the register bank
// Notes: purely combinational
`timescale 1ns/1ps
module wcc_level_dec
  import wcc_pkg::*;
(
  // pair codes
  input wire logic [11:0] pair_codes,
  // decoded selections
  output wcc_cur_t pair_cur [NUM_PAIRS]
);
  function automatic wcc_cur_t dec_code(input logic [2:0] code);
    wcc_cur_t r;
    unique case (code)
      3'h0: r = WCC_CUR_NONE;
      3'h1: r = WCC_CUR_1MA;
      3'h2: r = WCC_CUR_2MA;
      3'h3: r = WCC_CUR_5MA;
      3'h4: r = WCC_CUR_10MA;
      default: r = WCC_CUR_15MA; // RULE_01
    endcase
    return r;
  endfunction : dec_code

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    assign pair_cur[p] = dec_code(pair_codes[p*PAIR_CODE_W +: PAIR_CODE_W]); // RULE_01
  end
endmodule : wcc_level_dec

/* File: rtl/wcc_bank.sv */
// Purpose: wetting current configuration bank with pulsed wetting mode timing
// Assumes: Avalon-MM slave, byte address, one wait state per access
// Notes: pulse_start comes from logic on core_clk and is not synchronised
//
// Operation
// RULE_01 - pair code 0 none, 1/2/3/4 give 1/2/5/10 mA, 5-7 give 15 mA
// RULE_02 - pairs 12,14,16,18 at bits 2:0,5:3,8:6,11:9, reset to zero
// RULE_03 - activation time field 6:4 gives (code+1) times 64 us, reset zero
// RULE_04 - bits 0-3 pick 10 or 15 mA per six-input group
// RULE_05 - enable bit n activates pulsed current for input n
// RULE_06 - all pulsed enable bits reset to zero
// RULE_07 - timing register at index 0x1F, bits 23:7 read zero
// RULE_08 - enable register at index 0x20, 24 bits read/write, reset zero
// RULE_09 - reserved writes ignored; only enabled inputs pulse for the programmed time
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module wcc_bank
  import wcc_pkg::*;
#(
  parameter int unsigned PULSE_UNIT_CYCLES = PULSE_UNIT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // pulsed mode trigger
  input wire logic pulse_start,
  // continuous wetting current selection for pairs 12 to 19
  output wcc_cur_t pair_cur [NUM_PAIRS],
  // pulsed wetting current sources
  output logic [NUM_INPUTS-1:0] pulse_on,
  output logic [NUM_INPUTS-1:0] pulse_15ma,
  output logic pulse_busy
);
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  logic [11:0] pairs_q;
  wcc_pulse_cfg_t cfg_q;
  logic [23:0] en_q;
  logic ack_q;
  logic [31:0] rdata_q;
  wcc_state_t state_q;
  logic [13:0] pre_q;
  logic [3:0] units_q;
  logic [3:0] units_target_q;
  logic [NUM_INPUTS-1:0] on_q;
  wcc_state_t state_d;
  logic [13:0] pre_d;
  logic [3:0] units_d;
  logic [3:0] units_target_d;
  logic [NUM_INPUTS-1:0] on_d;

  // bus decode
  wire logic req = read | write;
  wire logic [7:0] word_idx = address[ADDR_W-1:2];
  wire logic hit_pairs = (word_idx == IDX_UPPER_PAIRS);
  wire logic hit_cfg = (word_idx == IDX_TIMING_LEVEL); // RULE_07
  wire logic hit_en = (word_idx == IDX_INPUT_ENABLE); // RULE_08
  wire logic do_write = write & ack_q;
  wire logic [31:0] cfg_word = {25'h000_0000, cfg_q.act_time, cfg_q.group_15ma}; // RULE_07
  wire logic [31:0] rd_mux = hit_pairs ? {20'h0_0000, pairs_q} :
                             hit_cfg ? cfg_word :
                             hit_en ? {8'h00, en_q} : READ_ZERO;
  wire logic [31:0] pairs_new = merge_bytes({20'h0_0000, pairs_q}, writedata, byteenable);
  wire logic [31:0] cfg_new = merge_bytes(cfg_word, writedata, byteenable);
  wire logic [31:0] en_new = merge_bytes({8'h00, en_q}, writedata, byteenable);

  // write strobes per register; a write lands only on the acknowledged cycle
  wire logic we_pairs = do_write & hit_pairs;
  wire logic we_cfg = do_write & hit_cfg;
  wire logic we_en = do_write & hit_en;
  // reserved bits are sliced off here, so writes to them are lost
  wire logic [11:0] pairs_d = we_pairs ? pairs_new[11:0] : pairs_q; // RULE_02
  wire wcc_pulse_cfg_t cfg_d = we_cfg ? wcc_pulse_cfg_t'(cfg_new[TIME_MSB:LEVEL_LSB]) : cfg_q; // RULE_09
  wire logic [23:0] en_d = we_en ? en_new[23:0] : en_q; // RULE_08

  // one wait state keeps read data registered without a combinational path to the bus
  wire logic first_cycle = req & ~ack_q;
  wire logic ack_d = first_cycle;
  wire logic [31:0] rdata_d = first_cycle ? (read ? rd_mux : READ_ZERO) : rdata_q;
  assign waitrequest = first_cycle;
  assign readdata = rdata_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= READ_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pairs_q <= UPPER_PAIRS_RST; // RULE_02
    end else begin
      pairs_q <= pairs_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= TIMING_LEVEL_RST; // RULE_07
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= INPUT_ENABLE_RST; // RULE_06
    end else begin
      en_q <= en_d;
    end
  end

  wcc_level_dec u_dec (
    .pair_codes(pairs_q),
    .pair_cur(pair_cur)
  );

  // pulse timing: a prescaler makes one enable per 64 us unit
  wire logic unit_tick = (pre_q == 14'(PULSE_UNIT_CYCLES - 1));
  wire logic pulse_done = unit_tick & (units_q == units_target_q);

  // a start is only taken when idle, so a second start cannot stretch a burst
  always_comb begin
    state_d = state_q;
    pre_d = pre_q;
    units_d = units_q;
    units_target_d = units_target_q;
    on_d = on_q;
    unique case (state_q)
      WCC_IDLE: begin
        if (pulse_start) begin
          state_d = WCC_ACTIVE;
          pre_d = 14'h0000;
          units_d = 4'h1;
          units_target_d = {1'b0, cfg_q.act_time} + 4'h1; // RULE_03
          on_d = en_q; // RULE_05
        end
      end
      WCC_ACTIVE: begin
        pre_d = unit_tick ? 14'h0000 : pre_q + 14'h0001;
        if (unit_tick) begin
          units_d = units_q + 4'h1;
        end
        if (pulse_done) begin
          state_d = WCC_IDLE;
          on_d = 24'h00_0000; // RULE_09
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= WCC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 14'h0000;
    end else begin
      pre_q <= pre_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      units_q <= 4'h0;
    end else begin
      units_q <= units_d;
    end
  end

  // the target is latched at start, so a new time code only affects the next burst
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      units_target_q <= 4'h0;
    end else begin
      units_target_q <= units_target_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      on_q <= 24'h00_0000;
    end else begin
      on_q <= on_d;
    end
  end

  // enable is gated live so clearing a bit stops that input at once
  assign pulse_on = on_q & en_q; // RULE_09
  assign pulse_busy = (state_q == WCC_ACTIVE);
  for (genvar n = 0; n < NUM_INPUTS; n++) begin : g_lvl
    assign pulse_15ma[n] = cfg_q.group_15ma[n / GROUP_SIZE]; // RULE_04
  end
endmodule : wcc_bank

/* File: testbench/wcc_bank_props.sv */
// Purpose: port checks for wcc_bank
// Assumes: one wait state per access
// Notes: a counter stands in for long repeats
`timescale 1ns/1ps
module wcc_bank_props
  import wcc_pkg::*;
#(parameter int unsigned PULSE_UNIT_CYCLES = PULSE_UNIT_CYC) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pulse
  input wire logic pulse_start,
  input wire logic [NUM_INPUTS-1:0] pulse_on,
  input wire logic [NUM_INPUTS-1:0] pulse_15ma,
  input wire logic pulse_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  int busy_q;
  wire [7:0] idx = address[9:2];
  wire rd_ok = read && !waitrequest;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) busy_q <= 0;
    else busy_q <= pulse_busy ? busy_q + 1 : 0;
  end
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("stuck");
  tim_rsv_a: assert property (rd_ok && idx == IDX_TIMING_LEVEL |-> readdata[31:7] == 0) else $error("rsv");
  en_rsv_a: assert property (rd_ok && idx == IDX_INPUT_ENABLE |-> readdata[31:24] == 0) else $error("rsv");
  unmapped_read_a: assert property (rd_ok && idx > IDX_INPUT_ENABLE |-> readdata == 0) else $error("unmapped");
  start_busy_a: assert property (pulse_start && !pulse_busy |=> pulse_busy) else $error("no start");
  on_busy_a: assert property (!pulse_busy |-> pulse_on == 0) else $error("stray");
  grp_lvl_a: assert property (pulse_15ma == {{6{pulse_15ma[18]}}, {6{pulse_15ma[12]}},
    {6{pulse_15ma[6]}}, {6{pulse_15ma[0]}}}) else $error("group");
  burst_len_a: assert property ($fell(pulse_busy) |-> busy_q % PULSE_UNIT_CYCLES == 0
    && busy_q <= 8 * PULSE_UNIT_CYCLES) else $error("length");
endmodule : wcc_bank_props

bind wcc_bank wcc_bank_props #(.PULSE_UNIT_CYCLES(PULSE_UNIT_CYCLES)) wcc_bank_props_i (
  .core_clk(core_clk),
  .rstn(rstn),
  .address(address),
  .read(read),
  .write(write),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .pulse_start(pulse_start),
  .pulse_on(pulse_on),
  .pulse_15ma(pulse_15ma),
  .pulse_busy(pulse_busy)
);

/* File: testbench/wcc_bank_bench.sv */
// Purpose: bench for wcc_bank
// Assumes: unit of 4 cycles
// Notes: byte lanes on except for one partial write
`timescale 1ns/1ps
module wcc_bank_bench
  import wcc_pkg::*;
;
  logic core_clk, rstn, read, write, pulse_start, pulse_busy, waitrequest;
  logic [9:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable = 4'hf;
  logic [23:0] pulse_on, pulse_15ma;
  wcc_cur_t pair_cur [NUM_PAIRS];
  int n_mismatch = 0;
  int compares = 0;
  wcc_bank #(.PULSE_UNIT_CYCLES(4)) wcc_bank_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .pulse_start(pulse_start),
    .pair_cur(pair_cur),
    .pulse_on(pulse_on),
    .pulse_15ma(pulse_15ma),
    .pulse_busy(pulse_busy)
  );
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // request held until waitrequest is seen low at a rising edge; read data taken there
  // ends on a falling edge so outputs have settled for the caller
  task automatic acc(logic w, logic [9:0] a, logic [31:0] d);
    @(posedge core_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 0;
    write <= 0;
    @(negedge core_clk);
  endtask : acc
  task automatic t_reset;
    for (int k = 0; k < 3; k++) begin
      acc(0, 10'h078 + 10'(4 * k), 0);
      chk("reg reset", q, 0);
    end
    chk("pair reset", pair_cur[3], WCC_CUR_NONE);
    chk("idle on", pulse_on, 0);
    chk("idle busy", pulse_busy, 0);
  endtask : t_reset
  task automatic t_access;
    logic [9:0] ad [3] = '{10'h080, 10'h07c, 10'h3fc};
    logic [31:0] ex [3] = '{32'h00ff_ffff, 32'h0000_007f, 0};
    for (int k = 0; k < 3; k++) begin
      acc(1, ad[k], '1);
      acc(0, ad[k], 0);
      chk("read back", q, ex[k]);
    end
    @(posedge core_clk);
    byteenable <= 4'h2;
    acc(1, 10'h080, 32'h0000_0000);
    @(posedge core_clk);
    byteenable <= 4'hf;
    acc(0, 10'h080, 0);
    chk("lane write", q, 32'h00ff_00ff);
  endtask : t_access
  task automatic t_decode;
    for (int c = 0; c < 8; c++) begin
      acc(1, 10'h078, 32'({3'(c + 3), 3'(c + 2), 3'(c + 1), 3'(c)}));
      for (int k = 0; k < 4; k++) chk("pair", pair_cur[k], (c + k) % 8 > 4 ? 5 : (c + k) % 8);
    end
  endtask : t_decode
  task automatic t_pulse;
    int n;
    acc(1, 10'h080, 32'h0081_0421);
    for (int c = 0; c < 8; c += 7) begin
      acc(1, 10'h07c, 32'(c * 16 + 10));
      @(posedge core_clk);
      pulse_start <= 1;
      @(posedge core_clk);
      pulse_start <= 0;
      @(negedge core_clk);
      chk("pulse on", pulse_on, 32'h0081_0421);
      chk("pulse level", pulse_15ma, 32'h00fc_0fc0);
      chk("pulse busy", pulse_busy, 1);
      for (n = 0; pulse_busy === 1'b1 && n < 99; n++) @(negedge core_clk);
      chk("burst", n, (c + 1) * 4);
      chk("pulse off", pulse_on, 0);
    end
  endtask : t_pulse
  initial begin
    rstn = 0;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    pulse_start = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1;
    t_reset();
    t_access();
    t_decode();
    t_pulse();
    report_and_stop();
  end
endmodule : wcc_bank_bench
